// ### axis_partner.sv
// Behavioural model of the axis controllers facing the guard
`timescale 1ns/1ps

module axis_partner
    import cmd_guard_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire cmd_out_t        cmd_i,
    input  wire logic [AXES-1:0] busy_i,
    input  wire logic [AXES-1:0] inh_i,
    input  wire logic            step_en_i,
    output axis_in_t             axis_o
);
    logic [2:0]      home_cnt_r;
    logic [AXW-1:0]  home_ax_r;
    logic [AXES-1:0] step_r;
    logic [AXES-1:0] done_r;

    assign axis_o = '{busy_i, inh_i, step_r, done_r};

    always_ff @(posedge clk_i) begin
        step_r <= '0;
        done_r <= '0;
        if (rst_i) begin
            home_cnt_r <= 3'h0;
            home_ax_r  <= 2'h0;
        end else begin
            // Homing takes a few cycles before the origin is found
            if (cmd_i.valid && cmd_i.op == OP_HOME) begin
                home_cnt_r <= 3'h3;
                home_ax_r  <= cmd_i.ax;
            end else if (home_cnt_r != 3'h0) begin
                home_cnt_r <= home_cnt_r - 3'h1;
                if (home_cnt_r == 3'h1)
                    done_r[home_ax_r] <= 1'b1;
            end
            if (cmd_i.valid && step_en_i &&
                cmd_i.op inside {OP_DIRECT, OP_INDIRECT, OP_LINEAR})
                step_r[cmd_i.ax] <= 1'b1;
        end
    end
endmodule : axis_partner

// ### cmd_guard_pkg.sv
// Constants, types and register map of the positioning command guard
package cmd_guard_pkg;

    localparam int AXES = 4;
    localparam int AXW  = 2;
    localparam int ERRW = 9;
    localparam int DW   = 32;
    localparam int ADW  = 8;

    // Register byte offsets
    localparam logic [ADW-1:0] REG_CMD    = 8'h00;
    localparam logic [ADW-1:0] REG_STATUS = 8'h04;
    localparam logic [ADW-1:0] REG_ERR    = 8'h08;
    localparam logic [ADW-1:0] REG_ACCEPT = 8'h0C;

    // Command register fields
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_OP_MSB   = 2;
    localparam int CMD_AX_LSB   = 4;
    localparam int CMD_AX_MSB   = 5;
    localparam int CMD_SUB_LSB  = 6;
    localparam int CMD_SUB_MSB  = 7;
    localparam int CMD_ABS_BIT  = 8;
    localparam int CMD_CSPD_BIT = 9;

    // Status register fields
    localparam int ST_BUSY_LSB  = 0;
    localparam int ST_INH_LSB   = 4;
    localparam int ST_STEP_LSB  = 8;
    localparam int ST_ORG_LSB   = 12;
    localparam int ST_PEND_BIT  = 16;
    localparam int ST_ERR_BIT   = 17;

    localparam logic [ERRW-1:0] ERR_NONE         = 9'h000;
    localparam logic [ERRW-1:0] ERR_HOME_BUSY    = 9'h0C9;
    localparam logic [ERRW-1:0] ERR_HOME_INH     = 9'h0CA;
    localparam logic [ERRW-1:0] ERR_FLOAT_BUSY   = 9'h0D3;
    localparam logic [ERRW-1:0] ERR_DIR_BUSY     = 9'h0DD;
    localparam logic [ERRW-1:0] ERR_DIR_INH      = 9'h0DE;
    localparam logic [ERRW-1:0] ERR_DIR_STEP     = 9'h0DF;
    localparam logic [ERRW-1:0] ERR_DIR_ORG      = 9'h0E0;
    localparam logic [ERRW-1:0] ERR_IND_BUSY     = 9'h0E7;
    localparam logic [ERRW-1:0] ERR_IND_INH      = 9'h0E8;
    localparam logic [ERRW-1:0] ERR_IND_STEP     = 9'h0E9;
    localparam logic [ERRW-1:0] ERR_IND_ORG      = 9'h0EA;
    localparam logic [ERRW-1:0] ERR_IND_CSPD     = 9'h0EC;
    localparam logic [ERRW-1:0] ERR_LIN_MBUSY    = 9'h0F1;
    localparam logic [ERRW-1:0] ERR_LIN_SBUSY    = 9'h0F2;
    localparam logic [ERRW-1:0] ERR_LIN_MINH     = 9'h0F4;
    localparam logic [ERRW-1:0] ERR_LIN_SINH     = 9'h0F5;
    localparam logic [ERRW-1:0] ERR_LIN_MSTEP    = 9'h0F7;
    localparam logic [ERRW-1:0] ERR_LIN_SSTEP    = 9'h0F8;
    localparam logic [ERRW-1:0] ERR_LIN_ORG      = 9'h0FA;

    typedef enum logic [2:0] {
        OP_NONE     = 3'h0,
        OP_HOME     = 3'h1,
        OP_FLOAT    = 3'h2,
        OP_DIRECT   = 3'h3,
        OP_INDIRECT = 3'h4,
        OP_LINEAR   = 3'h5,
        OP_STEP_OFF = 3'h6
    } op_t;

    typedef enum logic [1:0] {
        FSM_IDLE = 2'b01,
        FSM_EVAL = 2'b10
    } fsm_t;

    // Status from the axis controllers, same clock domain
    typedef struct packed {
        logic [AXES-1:0] busy;
        logic [AXES-1:0] inhibit;
        logic [AXES-1:0] step_set;
        logic [AXES-1:0] home_done;
    } axis_in_t;

    // Accepted command handed to the axis controllers
    typedef struct packed {
        logic           valid;
        op_t            op;
        logic [AXW-1:0] ax;
        logic [AXW-1:0] sub;
        logic           absolute;
    } cmd_out_t;

    typedef struct packed {
        fsm_t            fsm;
        op_t             op;
        logic [AXW-1:0]  ax;
        logic [AXW-1:0]  sub;
        logic            absolute;
        logic            cspd;
        logic [AXES-1:0] step_code;
        logic [AXES-1:0] origin;
        logic [ERRW-1:0] err;
        logic            rej;
        logic [15:0]     accepted;
        cmd_out_t        cmd;
        logic            ack;
        logic [DW-1:0]   dat;
    } state_t;

endpackage : cmd_guard_pkg

// ### positioning_command_guard.sv
// Command acceptance guard for a multi-axis pulse-train positioner
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps

module positioning_command_guard
    import cmd_guard_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            ce_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [ADW-1:0]  wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [DW-1:0]   wb_dat_i,
    output logic      [DW-1:0]   wb_dat_o,
    output logic                 wb_ack_o,
    input  wire axis_in_t        axis_i,
    output cmd_out_t             cmd_o,
    output logic      [AXES-1:0] step_code_o,
    output logic      [AXES-1:0] origin_o,
    output logic      [ERRW-1:0] err_code_o,
    output logic                 reject_o
);

    state_t st_r;
    state_t st_nxt;

    logic            req;
    logic            wr_ack;
    logic            rd_now;
    logic            cmd_wr;
    logic            err_wr;
    logic            eval;
    logic [ERRW-1:0] verdict;
    logic [DW-1:0]   status_word;
    logic [AXES-1:0] step_nx;
    logic [AXES-1:0] org_nx;

    // Single-wait-state slave: ack one cycle after the request shows
    assign req    = wb_cyc_i && wb_stb_i;
    assign rd_now = req && !st_r.ack;
    // Writes land on the edge where the master samples ack
    assign wr_ack = req && wb_we_i && st_r.ack;
    assign cmd_wr = wr_ack && wb_adr_i == REG_CMD && wb_sel_i[1:0] == 2'h3
                    && st_r.fsm == FSM_IDLE;
    assign err_wr = wr_ack && wb_adr_i == REG_ERR;
    assign eval   = st_r.fsm == FSM_EVAL;

    // Checks in the order the codes are numbered; first hit wins
    always_comb begin
        verdict = ERR_NONE;
        case (st_r.op)
            OP_HOME: begin
                if (axis_i.busy[st_r.ax])
                    verdict = ERR_HOME_BUSY;
                else if (axis_i.inhibit[st_r.ax])
                    verdict = ERR_HOME_INH;
            end
            OP_FLOAT: begin
                if (axis_i.busy[st_r.ax])
                    verdict = ERR_FLOAT_BUSY;
            end
            OP_DIRECT: begin
                if (axis_i.busy[st_r.ax])
                    verdict = ERR_DIR_BUSY;
                else if (axis_i.inhibit[st_r.ax])
                    verdict = ERR_DIR_INH;
                else if (st_r.step_code[st_r.ax])
                    verdict = ERR_DIR_STEP;
                else if (st_r.absolute && !st_r.origin[st_r.ax])
                    verdict = ERR_DIR_ORG;
            end
            OP_INDIRECT: begin
                if (axis_i.busy[st_r.ax])
                    verdict = ERR_IND_BUSY;
                else if (axis_i.inhibit[st_r.ax])
                    verdict = ERR_IND_INH;
                else if (st_r.step_code[st_r.ax])
                    verdict = ERR_IND_STEP;
                else if (st_r.absolute && !st_r.origin[st_r.ax])
                    verdict = ERR_IND_ORG;
                else if (st_r.cspd)
                    verdict = ERR_IND_CSPD;
            end
            OP_LINEAR: begin
                if (axis_i.busy[st_r.ax])
                    verdict = ERR_LIN_MBUSY;
                else if (axis_i.busy[st_r.sub])
                    verdict = ERR_LIN_SBUSY;
                else if (axis_i.inhibit[st_r.ax])
                    verdict = ERR_LIN_MINH;
                else if (axis_i.inhibit[st_r.sub])
                    verdict = ERR_LIN_SINH;
                else if (st_r.step_code[st_r.ax])
                    verdict = ERR_LIN_MSTEP;
                else if (st_r.step_code[st_r.sub])
                    verdict = ERR_LIN_SSTEP;
                else if (st_r.absolute && !st_r.origin[st_r.ax])
                    verdict = ERR_LIN_ORG;
            end
            default: verdict = ERR_NONE;
        endcase
    end

    // Per-axis step code and origin flags
    generate
        for (genvar a = 0; a < AXES; a++) begin : g_axis
            logic hit;
            logic ok;
            assign hit = eval && st_r.ax == AXW'(a);
            assign ok  = verdict == ERR_NONE;
            // Set from the axis wins over an off command in the same cycle
            assign step_nx[a] = axis_i.step_set[a]
                || (st_r.step_code[a]
                    && !(hit && st_r.op == OP_STEP_OFF));
            // Homing restarts the search, so origin is lost until done
            assign org_nx[a] = axis_i.home_done[a]
                || (hit && ok && st_r.op == OP_FLOAT)
                || (st_r.origin[a]
                    && !(hit && ok && st_r.op == OP_HOME));
        end
    endgenerate

    always_comb begin
        status_word = '0;
        status_word[ST_BUSY_LSB +: AXES] = axis_i.busy;
        status_word[ST_INH_LSB  +: AXES] = axis_i.inhibit;
        status_word[ST_STEP_LSB +: AXES] = st_r.step_code;
        status_word[ST_ORG_LSB  +: AXES] = st_r.origin;
        status_word[ST_PEND_BIT]         = st_r.fsm != FSM_IDLE;
        status_word[ST_ERR_BIT]          = st_r.err != ERR_NONE;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.cmd.valid = 1'b0;
        st_nxt.rej       = 1'b0;
        st_nxt.ack       = rd_now;
        st_nxt.step_code = step_nx;
        st_nxt.origin    = org_nx;

        if (rd_now) begin
            case (wb_adr_i)
                REG_CMD: begin
                    st_nxt.dat = '0;
                    st_nxt.dat[CMD_OP_MSB:CMD_OP_LSB]   = st_r.op;
                    st_nxt.dat[CMD_AX_MSB:CMD_AX_LSB]   = st_r.ax;
                    st_nxt.dat[CMD_SUB_MSB:CMD_SUB_LSB] = st_r.sub;
                    st_nxt.dat[CMD_ABS_BIT]             = st_r.absolute;
                    st_nxt.dat[CMD_CSPD_BIT]            = st_r.cspd;
                end
                REG_STATUS: st_nxt.dat = status_word;
                REG_ERR:    st_nxt.dat = {{(DW-ERRW){1'b0}}, st_r.err};
                REG_ACCEPT: st_nxt.dat = {16'h0000, st_r.accepted};
                default:    st_nxt.dat = '0;
            endcase
        end

        // Any write to the error register clears it, unless a refusal lands in the same cycle
        if (err_wr)
            st_nxt.err = ERR_NONE;

        case (st_r.fsm)
            FSM_IDLE: begin
                if (cmd_wr) begin
                    st_nxt.op       = op_t'(wb_dat_i[CMD_OP_MSB:CMD_OP_LSB]);
                    st_nxt.ax       = wb_dat_i[CMD_AX_MSB:CMD_AX_LSB];
                    st_nxt.sub      = wb_dat_i[CMD_SUB_MSB:CMD_SUB_LSB];
                    st_nxt.absolute = wb_dat_i[CMD_ABS_BIT];
                    st_nxt.cspd     = wb_dat_i[CMD_CSPD_BIT];
                    st_nxt.fsm      = FSM_EVAL;
                end
            end
            FSM_EVAL: begin
                st_nxt.fsm = FSM_IDLE;
                if (verdict != ERR_NONE) begin
                    // Refusal wins over a clear landing in the same cycle
                    st_nxt.err = verdict;
                    st_nxt.rej = 1'b1;
                end else if (st_r.op inside {OP_HOME, OP_FLOAT, OP_DIRECT,
                                             OP_INDIRECT, OP_LINEAR}) begin
                    st_nxt.cmd.valid    = 1'b1;
                    st_nxt.cmd.op       = st_r.op;
                    st_nxt.cmd.ax       = st_r.ax;
                    st_nxt.cmd.sub      = st_r.sub;
                    st_nxt.cmd.absolute = st_r.absolute;
                    st_nxt.accepted     = st_r.accepted + 16'h0001;
                end
            end
            default: st_nxt.fsm = FSM_IDLE;
        endcase

        if (!ce_i)
            st_nxt = st_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r           <= '0;
            st_r.fsm       <= FSM_IDLE;
            st_r.op        <= OP_NONE;
            st_r.cmd.op    <= OP_NONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o    = st_r.dat;
    assign wb_ack_o    = st_r.ack;
    assign cmd_o       = st_r.cmd;
    assign step_code_o = st_r.step_code;
    assign origin_o    = st_r.origin;
    assign err_code_o  = st_r.err;
    assign reject_o    = st_r.rej;

    // Checks on the guard's own decisions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_home_busy_code: assert property (
        eval && ce_i && st_r.op == OP_HOME && axis_i.busy[st_r.ax]
        |=> reject_o && err_code_o == 9'h0C9 && !cmd_o.valid)
        else $error("homing on busy axis not refused with 201");

    a_home_inh_code: assert property (
        eval && ce_i && st_r.op == OP_HOME && !axis_i.busy[st_r.ax]
        && axis_i.inhibit[st_r.ax]
        |=> err_code_o == 9'h0CA)
        else $error("homing on inhibited axis not refused with 202");

    a_float_busy_code: assert property (
        eval && ce_i && st_r.op == OP_FLOAT && axis_i.busy[st_r.ax]
        |=> err_code_o == 9'h0D3
            && origin_o == ($past(st_r.origin) | $past(axis_i.home_done)))
        else $error("floating origin on busy axis not refused with 211");

    a_direct_busy_code: assert property (
        eval && ce_i && st_r.op == OP_DIRECT && axis_i.busy[st_r.ax]
        |=> reject_o && err_code_o == 9'h0DD && !cmd_o.valid)
        else $error("direct start on busy axis not refused with 221");

    a_direct_inh_code: assert property (
        eval && ce_i && st_r.op == OP_DIRECT && !axis_i.busy[st_r.ax]
        && axis_i.inhibit[st_r.ax]
        |=> err_code_o == 9'h0DE && !cmd_o.valid)
        else $error("direct start on inhibited axis not refused with 222");

    a_direct_step_code: assert property (
        eval && ce_i && st_r.op == OP_DIRECT && !axis_i.busy[st_r.ax]
        && !axis_i.inhibit[st_r.ax] && st_r.step_code[st_r.ax]
        |=> err_code_o == 9'h0DF && !cmd_o.valid)
        else $error("direct start with step code on not refused");

    a_direct_org_code: assert property (
        eval && ce_i && st_r.op == OP_DIRECT && !axis_i.busy[st_r.ax]
        && !axis_i.inhibit[st_r.ax] && !st_r.step_code[st_r.ax]
        && st_r.absolute && !st_r.origin[st_r.ax]
        |=> reject_o && err_code_o == 9'h0E0 && !cmd_o.valid)
        else $error("absolute direct start origin check wrong");

    a_indirect_busy_code: assert property (
        eval && ce_i && st_r.op == OP_INDIRECT && axis_i.busy[st_r.ax]
        |=> reject_o && err_code_o == 9'h0E7 && !cmd_o.valid)
        else $error("indirect start on busy axis not refused with 231");

    a_indirect_inh_code: assert property (
        eval && ce_i && st_r.op == OP_INDIRECT && !axis_i.busy[st_r.ax]
        && axis_i.inhibit[st_r.ax]
        |=> err_code_o == 9'h0E8)
        else $error("indirect start on inhibited axis not refused");

    a_indirect_step_code: assert property (
        eval && ce_i && st_r.op == OP_INDIRECT && !axis_i.busy[st_r.ax]
        && !axis_i.inhibit[st_r.ax] && st_r.step_code[st_r.ax]
        |=> err_code_o == 9'h0E9 && !cmd_o.valid)
        else $error("indirect start with step code on not refused");

    a_indirect_org_code: assert property (
        eval && ce_i && st_r.op == OP_INDIRECT && !axis_i.busy[st_r.ax]
        && !axis_i.inhibit[st_r.ax] && !st_r.step_code[st_r.ax]
        && st_r.absolute && !st_r.origin[st_r.ax]
        |=> err_code_o == 9'h0EA && !cmd_o.valid)
        else $error("absolute indirect start origin check wrong");

    a_indirect_cspd: assert property (
        eval && ce_i && st_r.op == OP_INDIRECT && st_r.cspd
        |=> reject_o && err_code_o != 9'h000)
        else $error("continuous speed-control indirect start accepted");

    a_linear_main_busy: assert property (
        eval && ce_i && st_r.op == OP_LINEAR && axis_i.busy[st_r.ax]
        |=> reject_o && err_code_o == 9'h0F1 && !cmd_o.valid)
        else $error("linear start with busy main axis not refused");

    a_linear_sub_busy: assert property (
        eval && ce_i && st_r.op == OP_LINEAR && !axis_i.busy[st_r.ax]
        && axis_i.busy[st_r.sub]
        |=> err_code_o == 9'h0F2)
        else $error("linear start with busy sub axis not refused");

    a_linear_main_inh: assert property (
        eval && ce_i && st_r.op == OP_LINEAR && !axis_i.busy[st_r.ax]
        && !axis_i.busy[st_r.sub] && axis_i.inhibit[st_r.ax]
        |=> err_code_o == 9'h0F4)
        else $error("linear start with inhibited main axis not refused");

    a_linear_sub_inh: assert property (
        eval && ce_i && st_r.op == OP_LINEAR && !axis_i.busy[st_r.ax]
        && !axis_i.busy[st_r.sub] && !axis_i.inhibit[st_r.ax]
        && axis_i.inhibit[st_r.sub]
        |=> err_code_o == 9'h0F5)
        else $error("linear start with inhibited sub axis not refused");

    a_linear_main_step: assert property (
        eval && ce_i && st_r.op == OP_LINEAR && !axis_i.busy[st_r.ax]
        && !axis_i.busy[st_r.sub] && !axis_i.inhibit[st_r.ax]
        && !axis_i.inhibit[st_r.sub] && st_r.step_code[st_r.ax]
        |=> err_code_o == 9'h0F7)
        else $error("linear start with main step code on not refused");

    a_linear_sub_step: assert property (
        eval && ce_i && st_r.op == OP_LINEAR && !axis_i.busy[st_r.ax]
        && !axis_i.busy[st_r.sub] && !axis_i.inhibit[st_r.ax]
        && !axis_i.inhibit[st_r.sub] && !st_r.step_code[st_r.ax]
        && st_r.step_code[st_r.sub]
        |=> err_code_o == 9'h0F8)
        else $error("linear sub axis step code check wrong");

    a_linear_org_code: assert property (
        eval && ce_i && st_r.op == OP_LINEAR && st_r.absolute
        && !st_r.origin[st_r.ax]
        |=> reject_o && !cmd_o.valid)
        else $error("absolute linear start without origin issued");

    a_step_off_clr: assert property (
        eval && ce_i && st_r.op == OP_STEP_OFF
        && !axis_i.step_set[st_r.ax]
        |=> !step_code_o[$past(st_r.ax)])
        else $error("step code off command did not clear the flag");

    a_float_origin_set: assert property (
        eval && ce_i && st_r.op == OP_FLOAT && !axis_i.busy[st_r.ax]
        |=> origin_o[$past(st_r.ax)] && cmd_o.valid)
        else $error("floating origin accepted without origin set");

    a_reject_no_cmd: assert property (
        reject_o |-> !cmd_o.valid && err_code_o != 9'h000
        && $past(st_r.fsm == FSM_EVAL || !ce_i))
        else $error("refusal issued a command or lost its code");

endmodule : positioning_command_guard

// ### positioning_command_guard_tb.sv
// Self-checking bench for the positioning command guard
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
end

module positioning_command_guard_tb
    import cmd_guard_pkg::*;
;
    logic clk, rst, ce, cyc, stb, we, ack, rej, step_en;
    logic [ADW-1:0]  adr;
    logic [3:0]      sel;
    logic [DW-1:0]   wdat, rdat, q;
    logic [AXES-1:0] busy, inh, stc, org, m_step, m_org;
    logic [ERRW-1:0] err, m_err;
    cmd_out_t        cmd;
    axis_in_t        ax_st;
    int              bad_count, n_checks, m_acc;
    integer          seed = 32'h3d3aeb97;

    positioning_command_guard uut (
        .clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .axis_i(ax_st), .cmd_o(cmd), .step_code_o(stc),
        .origin_o(org), .err_code_o(err), .reject_o(rej));

    axis_partner far_end (
        .clk_i(clk), .rst_i(rst), .cmd_i(cmd), .busy_i(busy),
        .inh_i(inh), .step_en_i(step_en), .axis_o(ax_st));

    always #4 clk = ~clk;

    function automatic logic [ERRW-1:0] exp_code(op_t op,
        logic [AXW-1:0] a, logic [AXW-1:0] s, logic ab, logic cs);
        case (op)
            OP_HOME: return busy[a] ? ERR_HOME_BUSY :
                inh[a] ? ERR_HOME_INH : ERR_NONE;
            OP_FLOAT: return busy[a] ? ERR_FLOAT_BUSY : ERR_NONE;
            OP_DIRECT: return busy[a] ? ERR_DIR_BUSY :
                inh[a] ? ERR_DIR_INH : m_step[a] ? ERR_DIR_STEP :
                (ab && !m_org[a]) ? ERR_DIR_ORG : ERR_NONE;
            OP_INDIRECT: return busy[a] ? ERR_IND_BUSY :
                inh[a] ? ERR_IND_INH : m_step[a] ? ERR_IND_STEP :
                (ab && !m_org[a]) ? ERR_IND_ORG :
                cs ? ERR_IND_CSPD : ERR_NONE;
            OP_LINEAR: return busy[a] ? ERR_LIN_MBUSY :
                busy[s] ? ERR_LIN_SBUSY : inh[a] ? ERR_LIN_MINH :
                inh[s] ? ERR_LIN_SINH : m_step[a] ? ERR_LIN_MSTEP :
                m_step[s] ? ERR_LIN_SSTEP :
                (ab && !m_org[a]) ? ERR_LIN_ORG : ERR_NONE;
            default: return ERR_NONE;
        endcase
    endfunction : exp_code

    // Classic single cycle; the caller stands just after a rising edge
    task automatic wb_io(input logic w, input logic [ADW-1:0] a,
        input logic [DW-1:0] d, output logic [DW-1:0] r);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        sel <= 4'hF;
        // Only the watchdog ends a wait that never sees ack
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        `CHK(ack, 1'b1)
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask : wb_io

    task automatic run_cmd(input op_t op, input logic [AXW-1:0] a,
        input logic [AXW-1:0] s, input logic ab, input logic cs);
        logic [ERRW-1:0] e;
        int nr, nv;
        logic is_start;
        cmd_out_t c;
        nr = 0;
        nv = 0;
        c = '0;
        wb_io(1'b1, REG_CMD, {22'h0, cs, ab, s, a, 1'b0, op}, q);
        // Axis inputs settled by now, so expectation is taken here
        e = exp_code(op, a, s, ab, cs);
        is_start = op inside {OP_HOME, OP_FLOAT, OP_DIRECT,
                              OP_INDIRECT, OP_LINEAR};
        repeat (10) begin
            @(posedge clk);
            if (rej === 1'b1) nr++;
            if (cmd.valid === 1'b1) begin
                nv++;
                c = cmd;
            end
        end
        `CHK(nr, (is_start && e != ERR_NONE) ? 1 : 0)
        `CHK(nv, (is_start && e == ERR_NONE) ? 1 : 0)
        if (is_start && e != ERR_NONE) begin
            m_err = e;
        end else if (is_start) begin
            `CHK({c.op, c.ax, c.absolute}, {op, a, ab})
            m_acc++;
            if (op == OP_LINEAR) `CHK(c.sub, s)
            if (op inside {OP_HOME, OP_FLOAT}) m_org[a] = 1'b1;
            else if (step_en) m_step[a] = 1'b1;
        end else if (op == OP_STEP_OFF) begin
            m_step[a] = 1'b0;
        end
        `CHK(err, m_err)
        `CHK(stc, m_step)
        `CHK(org, m_org)
    endtask : run_cmd

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        #200000;
        bad_count++;
        finish_test();
    end

    initial begin
        clk = 0; rst = 1; ce = 1; cyc = 0; stb = 0; we = 0;
        adr = '0; sel = 4'hF; wdat = '0; busy = '0; inh = '0;
        step_en = 0; m_step = '0; m_org = '0; m_err = '0;
        bad_count = 0; n_checks = 0; m_acc = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK({err, stc, org, rej}, 18'h0)
        wb_io(1'b0, REG_ACCEPT, 32'h0, q);
        `CHK(q, 32'h0)
        wb_io(1'b0, 8'h10, 32'h0, q);
        `CHK(q, 32'h0)
        // Origins unknown and no step codes yet
        run_cmd(OP_LINEAR, 2'h2, 2'h3, 1'b1, 1'b0);
        run_cmd(OP_DIRECT, 2'h0, 2'h1, 1'b1, 1'b0);
        run_cmd(OP_INDIRECT, 2'h1, 2'h0, 1'b1, 1'b0);
        run_cmd(OP_FLOAT, 2'h0, 2'h0, 1'b0, 1'b0);
        step_en <= 1'b1;
        run_cmd(OP_DIRECT, 2'h0, 2'h1, 1'b1, 1'b0);
        run_cmd(OP_DIRECT, 2'h0, 2'h1, 1'b0, 1'b0);
        run_cmd(OP_STEP_OFF, 2'h0, 2'h0, 1'b0, 1'b0);
        run_cmd(OP_DIRECT, 2'h0, 2'h1, 1'b0, 1'b0);
        run_cmd(OP_STEP_OFF, 2'h0, 2'h0, 1'b0, 1'b0);
        // Enable low must hold the bus answer and the clear back
        ce <= 1'b0;
        fork
            wb_io(1'b1, REG_ERR, 32'h0, q);
            begin
                repeat (4) begin
                    @(posedge clk);
                    `CHK(ack, 1'b0)
                end
                ce <= 1'b1;
            end
        join
        m_err = '0;
        `CHK(err, ERR_NONE)
        repeat (400) begin
            busy <= 4'($random(seed) & $random(seed));
            inh <= 4'($random(seed) & $random(seed));
            step_en <= 1'($random(seed));
            run_cmd(op_t'(3'($random(seed))), 2'($random(seed)),
                2'($random(seed)), 1'($random(seed)),
                1'($random(seed)));
            if (2'($random(seed)) == 2'h0) begin
                wb_io(1'b1, REG_ERR, 32'($random(seed)), q);
                m_err = '0;
                `CHK(err, ERR_NONE)
            end
            if (3'($random(seed)) == 3'h0) begin
                wb_io(1'b0, REG_STATUS, 32'h0, q);
                `CHK(q[17:0], {m_err != '0, 1'b0, m_org, m_step, inh,
                    busy})
                wb_io(1'b0, REG_ERR, 32'h0, q);
                `CHK(q[ERRW-1:0], m_err)
                wb_io(1'b0, REG_ACCEPT, 32'h0, q);
                `CHK(q, 32'(m_acc))
            end
        end
        finish_test();
    end
endmodule : positioning_command_guard_tb
